/* include/rtcaux_pkg.sv */
// constants and types shared by the clock auxiliary block
package rtcaux_pkg;
   // ------------------------------------------------------------
   // register indices on the plain register port
   // ------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam logic [4:0] A_CTL1L = 5'h00;
   localparam logic [4:0] A_CTL1H = 5'h01;
   localparam logic [4:0] A_CTL2L = 5'h02;
   localparam logic [4:0] A_CTL3L = 5'h03;
   localparam logic [4:0] A_DIV = 5'h04;
   localparam logic [4:0] A_FINE_DIVIDE = 5'h05;
   localparam logic [4:0] A_STAT = 5'h06;
   localparam logic [4:0] A_ALM0 = 5'h08;
   localparam logic [4:0] A_STAMP0 = 5'h0c;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int B_STAMP_EN = 0;
   localparam int B_PIN_OUTPUT_SELECT_LO = 4;
   localparam int B_PIN_OE = 7;
   localparam int B_PWC_POL = 9;
   localparam int B_PWC_EN = 10;
   localparam int B_MOD_EN = 15;
   localparam int B_ALM_EN = 15;
   localparam int B_ENDLESS = 14;
   localparam int B_MASK_LO = 8;
   localparam int B_PS_LO = 6;
   localparam int B_STAMP_FLAG = 3;
   // ------------------------------------------------------------
   // reset values and special codes
   // ------------------------------------------------------------
   localparam logic [15:0] CTL_RST = 16'h0000;
   localparam logic [15:0] DIV_RST = 16'h3fff;
   localparam logic [4:0] FINE_DIVIDE_RST = 5'h00;
   localparam logic [7:0] RPT_WRAP = 8'hff;
   localparam logic [7:0] STAB_CONT = 8'hff;
   localparam logic [7:0] WIN_OFF = 8'h00;
   localparam logic [2:0] SEL_ALARM = 3'h0;
   localparam logic [2:0] SEL_PWC = 3'h3;
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV16 = 2'h1;
   localparam logic [1:0] PS_DIV64 = 2'h2;
   localparam logic [7:0] PS_M16 = 8'h0f;
   localparam logic [7:0] PS_M64 = 8'h3f;
   localparam logic [7:0] PS_M256 = 8'hff;
   // sequencer states
   typedef enum logic [1:0] {PWC_IDLE, PWC_STAB, PWC_SAMP} rtcaux_pwc_state_t;
endpackage

/* src/rtcaux_pwc_seq.sv */
// power-control sequencer: control output, stability and sample windows
`timescale 1ns/10ps
`default_nettype none
module rtcaux_pwc_seq (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic start,
   input wire logic pwc_tick,
   input wire logic [7:0] stab_len,
   input wire logic [7:0] samp_len,
   output logic ctl_q,
   output logic stab_win_q,
   output logic gate_q
);
   rtcaux_pkg::rtcaux_pwc_state_t state_q;
   logic [7:0] cnt_q;

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !enable) begin
         state_q <= rtcaux_pkg::PWC_IDLE;
         cnt_q <= 8'h00;
         ctl_q <= 1'b0;
         gate_q <= 1'b0;
      end else begin
         case (state_q)
            rtcaux_pkg::PWC_IDLE: begin
               if (start && stab_len != rtcaux_pkg::WIN_OFF) begin
                  ctl_q <= 1'b1;
                  cnt_q <= stab_len;
                  state_q <= rtcaux_pkg::PWC_STAB;
               end else if (start && samp_len != rtcaux_pkg::WIN_OFF) begin
                  ctl_q <= 1'b1;
                  gate_q <= 1'b1;
                  cnt_q <= samp_len;
                  state_q <= rtcaux_pkg::PWC_SAMP;
               end
            end
            rtcaux_pkg::PWC_STAB: begin
               if (pwc_tick && cnt_q == 8'h01) begin
                  if (samp_len != rtcaux_pkg::WIN_OFF) begin
                     gate_q <= 1'b1;
                     cnt_q <= samp_len;
                     state_q <= rtcaux_pkg::PWC_SAMP;
                  end else begin
                     ctl_q <= 1'b0;
                     state_q <= rtcaux_pkg::PWC_IDLE;
                  end
               end else if (pwc_tick) begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: begin
               // the sample window closes and the device is powered down
               if (pwc_tick && cnt_q == 8'h01) begin
                  ctl_q <= 1'b0;
                  gate_q <= 1'b0;
                  state_q <= rtcaux_pkg::PWC_IDLE;
               end else if (pwc_tick) begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
         endcase
      end
   end

   // full-scale stability length holds the window open
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stab_win_q <= 1'b0;
      end else begin
         stab_win_q <= (stab_len == rtcaux_pkg::STAB_CONT) || (state_q == rtcaux_pkg::PWC_STAB);
      end
   end

   gate_ctl_a: assert property (@(posedge sys_clk) disable iff (!rst_n) gate_q |-> ctl_q)
      else $error("sample gate without control output");
   stab_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_q == rtcaux_pkg::PWC_IDLE && enable && start && stab_len != 8'h00 |=> ctl_q && !gate_q)
      else $error("stability window did not open first");
endmodule
`default_nettype wire

/* src/rtcaux_top.sv */
// clock auxiliary block: prescaler, alarm, power control, timestamp
`timescale 1ns/10ps
`default_nettype none
module rtcaux_top (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic por_n,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata_q,
   input wire logic [15:0] cur_time_low,
   input wire logic [15:0] cur_time_high,
   input wire logic [15:0] cur_date_low,
   input wire logic [15:0] cur_date_high,
   input wire logic tamper_input_n,
   output logic half_tick_q,
   output logic sec_tick_q,
   output logic alarm_irq_q,
   output logic clock_irq_q,
   output logic clock_pin_q,
   output logic clock_pin_oe_q,
   output logic sample_gate_q,
   output logic stab_window_q
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // digit match selected by the mask code
   function automatic logic mask_match(input logic [3:0] m, input logic [15:0] tl, input logic [15:0] th,
                                       input logic [15:0] dl, input logic [15:0] dh,
                                       input logic [15:0] al [4]);
      logic s1, s10, m1, m10, h, wd, dd, mo;
      s1 = tl[11:8] == al[0][11:8];
      s10 = tl[14:12] == al[0][14:12];
      m1 = th[3:0] == al[1][3:0];
      m10 = th[6:4] == al[1][6:4];
      h = th[13:8] == al[1][13:8];
      wd = dl[2:0] == al[2][2:0];
      dd = dl[13:8] == al[2][13:8];
      mo = dh[4:0] == al[3][4:0];
      case (m)
         4'h0, 4'h1: mask_match = 1'b1;
         4'h2: mask_match = s1;
         4'h3: mask_match = s1 && s10;
         4'h4: mask_match = s1 && s10 && m1;
         4'h5: mask_match = s1 && s10 && m1 && m10;
         4'h6: mask_match = s1 && s10 && m1 && m10 && h;
         4'h7: mask_match = s1 && s10 && m1 && m10 && h && wd;
         4'h8: mask_match = s1 && s10 && m1 && m10 && h && dd;
         4'h9: mask_match = s1 && s10 && m1 && m10 && h && dd && mo;
         default: mask_match = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] ps_mask(input logic [1:0] code);
      case (code)
         rtcaux_pkg::PS_DIV1: ps_mask = 8'h00;
         rtcaux_pkg::PS_DIV16: ps_mask = rtcaux_pkg::PS_M16;
         rtcaux_pkg::PS_DIV64: ps_mask = rtcaux_pkg::PS_M64;
         default: ps_mask = rtcaux_pkg::PS_M256;
      endcase
   endfunction

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   logic [15:0] ctl1l_q, ctl2l_q, ctl3l_q, div_q;
   logic [4:0] fine_divide_q;
   logic alm_en_q, endless_q;
   logic [3:0] mask_q;
   logic [7:0] rpt_q;
   logic [15:0] alm_q [4];
   logic [15:0] stamp_q [4];
   logic stamp_flag_q, stamp_pend_q;
   logic fire, stamp_evt, manual_req, flag_clr;
   logic wr_ctl1h;

   assign wr_ctl1h = reg_wr && reg_addr == rtcaux_pkg::A_CTL1H;

   // plain control words
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctl1l_q <= rtcaux_pkg::CTL_RST;
         ctl2l_q <= rtcaux_pkg::CTL_RST;
         ctl3l_q <= rtcaux_pkg::CTL_RST;
         div_q <= rtcaux_pkg::DIV_RST;
         fine_divide_q <= rtcaux_pkg::FINE_DIVIDE_RST;
      end else if (reg_wr) begin
         if (reg_addr == rtcaux_pkg::A_CTL1L) begin
            ctl1l_q <= reg_wdata;
         end else if (reg_addr == rtcaux_pkg::A_CTL2L) begin
            ctl2l_q <= reg_wdata;
         end else if (reg_addr == rtcaux_pkg::A_CTL3L) begin
            ctl3l_q <= reg_wdata;
         end else if (reg_addr == rtcaux_pkg::A_DIV) begin
            div_q <= reg_wdata;
         end else if (reg_addr == rtcaux_pkg::A_FINE_DIVIDE) begin
            fine_divide_q <= reg_wdata[4:0];
         end
      end
   end

   // alarm value words, not reset so a warm reset keeps them
   always_ff @(posedge sys_clk) begin
      if (reg_wr && reg_addr[4:2] == rtcaux_pkg::A_ALM0[4:2]) begin
         alm_q[reg_addr[1:0]] <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // one-second prescaler
   // ------------------------------------------------------------
   logic [20:0] pre_cnt_q;
   logic [20:0] pre_val;
   logic mod_en;
   assign mod_en = ctl1l_q[rtcaux_pkg::B_MOD_EN];

   // coarse and fine joined as one 21-bit terminal count
   assign pre_val = {div_q, fine_divide_q};

   // period is pre_val plus one clocks, so either field scales it
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !mod_en) begin
         pre_cnt_q <= 21'h000000;
         sec_tick_q <= 1'b0;
         half_tick_q <= 1'b0;
      end else begin
         sec_tick_q <= pre_cnt_q >= pre_val;
         half_tick_q <= (pre_cnt_q >= pre_val) || (pre_cnt_q == {1'b0, pre_val[20:1]});
         if (pre_cnt_q >= pre_val) begin
            pre_cnt_q <= 21'h000000;
         end else begin
            pre_cnt_q <= pre_cnt_q + 21'h000001;
         end
      end
   end

   // ------------------------------------------------------------
   // alarm
   // ------------------------------------------------------------
   logic eval_half_q, eval_sec_q;

   // compare a cycle after the tick so the calendar has advanced
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         eval_half_q <= 1'b0;
         eval_sec_q <= 1'b0;
      end else begin
         eval_half_q <= half_tick_q;
         eval_sec_q <= sec_tick_q;
      end
   end

   // half-second code fires on every half tick
   assign fire = alm_en_q && (mask_q == 4'h0 ? eval_half_q : eval_sec_q)
                 && mask_match(mask_q, cur_time_low, cur_time_high, cur_date_low, cur_date_high, alm_q);

   // hardware update after a write so the end of sequence always wins
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         alm_en_q <= 1'b0;
         endless_q <= 1'b0;
         mask_q <= 4'h0;
         rpt_q <= 8'h00;
      end else if (fire) begin
         if (wr_ctl1h) begin
            endless_q <= reg_wdata[rtcaux_pkg::B_ENDLESS];
            mask_q <= reg_wdata[rtcaux_pkg::B_MASK_LO +: 4];
         end
         // endless repeat rolls over and keeps going
         if (rpt_q == 8'h00 && endless_q) begin
            rpt_q <= rtcaux_pkg::RPT_WRAP;
         // last alarm of the sequence turns the alarm off
         end else if (rpt_q == 8'h00) begin
            alm_en_q <= 1'b0;
         end else begin
            rpt_q <= rpt_q - 8'h01;
         end
      end else if (wr_ctl1h) begin
         alm_en_q <= reg_wdata[rtcaux_pkg::B_ALM_EN];
         endless_q <= reg_wdata[rtcaux_pkg::B_ENDLESS];
         mask_q <= reg_wdata[rtcaux_pkg::B_MASK_LO +: 4];
         rpt_q <= reg_wdata[7:0]; // repeat count load
      end
   end

   // ------------------------------------------------------------
   // power control
   // ------------------------------------------------------------
   logic [7:0] pwc_div_q;
   logic pwc_tick_q, pwc_ctl;

   // power-control clock scaled by prescaler at bits 7:6
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !mod_en) begin
         pwc_div_q <= 8'h00;
         pwc_tick_q <= 1'b0;
      end else begin
         pwc_tick_q <= (pwc_div_q & ps_mask(ctl2l_q[rtcaux_pkg::B_PS_LO +: 2])) == 8'h00;
         pwc_div_q <= pwc_div_q + 8'h01;
      end
   end

   // sample length high byte, stability length low byte
   rtcaux_pwc_seq u_seq (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(mod_en && ctl1l_q[rtcaux_pkg::B_PWC_EN]),
      .start(fire),
      .pwc_tick(pwc_tick_q),
      .stab_len(ctl3l_q[7:0]),
      .samp_len(ctl3l_q[15:8]),
      .ctl_q(pwc_ctl),
      .stab_win_q(stab_window_q),
      .gate_q(sample_gate_q)
   );

   // alarm pulse; pin mux follows the output select field
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         alarm_irq_q <= 1'b0;
         clock_pin_q <= 1'b0;
         clock_pin_oe_q <= 1'b0;
      end else begin
         alarm_irq_q <= fire;
         clock_pin_oe_q <= ctl1l_q[rtcaux_pkg::B_PIN_OE];
         if (ctl1l_q[rtcaux_pkg::B_PIN_OUTPUT_SELECT_LO +: 3] == rtcaux_pkg::SEL_PWC) begin
            clock_pin_q <= ctl1l_q[rtcaux_pkg::B_PWC_POL] ? pwc_ctl : !pwc_ctl;
         end else if (ctl1l_q[rtcaux_pkg::B_PIN_OUTPUT_SELECT_LO +: 3] == rtcaux_pkg::SEL_ALARM) begin
            clock_pin_q <= fire;
         end else begin
            clock_pin_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // timestamp
   // ------------------------------------------------------------
   logic tmp_s1_q, tmp_s2_q, tmp_prev_q, tmp_armed_q;
   logic stamp_en;
   assign stamp_en = ctl1l_q[rtcaux_pkg::B_STAMP_EN];

   // two-stage synchroniser, only stage two is read
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tmp_s1_q <= 1'b1;
         tmp_s2_q <= 1'b1;
         tmp_prev_q <= 1'b1;
         tmp_armed_q <= 1'b0;
      end else begin
         tmp_s1_q <= tamper_input_n;
         tmp_s2_q <= tmp_s1_q;
         tmp_prev_q <= tmp_s2_q;
         if (tmp_prev_q && !tmp_s2_q) begin
            tmp_armed_q <= 1'b1;
         end else if (!tmp_prev_q && tmp_s2_q) begin
            tmp_armed_q <= 1'b0;
         end
      end
   end

   assign manual_req = reg_wr && reg_addr == rtcaux_pkg::A_STAT && reg_wdata[rtcaux_pkg::B_STAMP_FLAG];
   assign flag_clr = reg_wr && reg_addr == rtcaux_pkg::A_STAT && !reg_wdata[rtcaux_pkg::B_STAMP_FLAG];

   // low pulse completes on its rising edge
   // no capture while the flag stands
   assign stamp_evt = stamp_en && !stamp_flag_q
                      && ((tmp_armed_q && !tmp_prev_q && tmp_s2_q) || stamp_pend_q);

   // a one written to the flag only requests a capture
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stamp_pend_q <= 1'b0;
      end else begin
         stamp_pend_q <= manual_req && stamp_en && !stamp_flag_q;
      end
   end

   // flag set on capture; set wins over a same-cycle clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stamp_flag_q <= 1'b0;
         clock_irq_q <= 1'b0;
      end else begin
         clock_irq_q <= stamp_evt || fire;
         if (stamp_evt) begin
            stamp_flag_q <= 1'b1;
         end else if (flag_clr) begin
            stamp_flag_q <= 1'b0;
         end
      end
   end

   // cleared by power-on reset only; storage while disabled
   always_ff @(posedge sys_clk) begin
      if (!por_n) begin
         stamp_q <= '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
      end else if (stamp_evt) begin
         stamp_q <= '{cur_time_low, cur_time_high, cur_date_low, cur_date_high};
      end else if (reg_wr && !stamp_en && reg_addr[4:2] == rtcaux_pkg::A_STAMP0[4:2]) begin
         stamp_q[reg_addr[1:0]] <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // read port, data one cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata_q <= 16'h0000;
      end else if (!reg_rd) begin
         reg_rdata_q <= 16'h0000;
      end else if (reg_addr == rtcaux_pkg::A_CTL1L) begin
         reg_rdata_q <= ctl1l_q;
      end else if (reg_addr == rtcaux_pkg::A_CTL1H) begin
         reg_rdata_q <= {alm_en_q, endless_q, 2'h0, mask_q, rpt_q};
      end else if (reg_addr == rtcaux_pkg::A_CTL2L) begin
         reg_rdata_q <= ctl2l_q;
      end else if (reg_addr == rtcaux_pkg::A_CTL3L) begin
         reg_rdata_q <= ctl3l_q;
      end else if (reg_addr == rtcaux_pkg::A_DIV) begin
         reg_rdata_q <= div_q;
      end else if (reg_addr == rtcaux_pkg::A_FINE_DIVIDE) begin
         reg_rdata_q <= {11'h000, fine_divide_q};
      end else if (reg_addr == rtcaux_pkg::A_STAT) begin
         reg_rdata_q <= {12'h000, stamp_flag_q, 3'h0};
      end else if (reg_addr[4:2] == rtcaux_pkg::A_ALM0[4:2]) begin
         reg_rdata_q <= alm_q[reg_addr[1:0]];
      end else if (reg_addr[4:2] == rtcaux_pkg::A_STAMP0[4:2]) begin
         reg_rdata_q <= stamp_q[reg_addr[1:0]];
      end else begin
         reg_rdata_q <= 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence manual_done_s;
      !stamp_flag_q ##1 stamp_flag_q;
   endsequence

   alarm_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fire && rpt_q == 8'h00 && !endless_q |=> !alm_en_q)
      else $error("alarm stayed enabled after last alarm");
   repeat_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fire && rpt_q != 8'h00 |=> rpt_q == $past(rpt_q) - 8'h01)
      else $error("repeat count did not decrement");
   endless_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fire && rpt_q == 8'h00 && endless_q |=> rpt_q == 8'hff && alm_en_q)
      else $error("endless repeat did not wrap");
   alarm_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fire |=> alarm_irq_q && clock_irq_q)
      else $error("alarm without interrupt pulse");
   half_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      alm_en_q && mask_q == 4'h0 && eval_half_q |=> alarm_irq_q)
      else $error("half-second alarm missed");
   stamp_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stamp_evt |=> stamp_flag_q && stamp_q[0] == $past(cur_time_low))
      else $error("timestamp capture incomplete");
   stamp_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stamp_flag_q && stamp_en |=> $stable(stamp_q[3]) && $stable(stamp_q[0]))
      else $error("capture while flag set");
   manual_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      manual_req && stamp_en && !stamp_flag_q |=> manual_done_s)
      else $error("manual capture sequence wrong");
endmodule
`default_nettype wire

/* test/rtcaux_ext_dev.sv */
// switched external device model and tamper pulse source
`timescale 1ns/10ps
`default_nettype none
module rtcaux_ext_dev (
   input wire logic sys_clk,
   input wire logic pin,
   input wire logic pin_oe,
   input wire logic gate,
   input wire logic pulse_req,
   output logic tamper_n,
   output int gate_len,
   output logic unpowered
);
   int low_cnt = 0;
   logic prev = 1'b0;
   initial begin
      tamper_n = 1'b1;
      gate_len = 0;
      unpowered = 1'b0;
   end
   always @(posedge sys_clk) begin
      low_cnt <= pulse_req ? 3 : (low_cnt > 0 ? low_cnt - 1 : 0);
      tamper_n <= !(pulse_req || low_cnt > 1);
   end
   // gate length; sampling unpowered is a fault
   always @(posedge sys_clk) begin
      prev <= gate;
      if (gate === 1'b1) gate_len <= prev ? gate_len + 1 : 1;
      if (gate === 1'b1 && (pin !== 1'b1 || pin_oe !== 1'b1)) unpowered <= 1'b1;
   end
endmodule
`default_nettype wire

/* test/rtcaux_test.sv */
// self-checking bench for the clock auxiliary block
`timescale 1ns/10ps
`default_nettype none
module rtcaux_test;
   // ----
   // stimulus and checks
   // ----
   logic sys_clk = 0, rst_n = 0, por_n = 0, reg_wr = 0, reg_rd = 0, pulse_req = 0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000, d, rdata;
   logic [15:0] cur [4] = '{default: 16'h0000};
   logic [15:0] e [4];
   logic tamper_n, half, sec, pin, pin_oe, gate, stab, cirq, airq, unpow;
   int seed = 94149, num_errors = 0, check_count = 0, n_alm = 0, n_irq = 0, n_half = 0, glen, i, n;
   logic [4:0] f;
   rtcaux_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata),
      .cur_time_low(cur[0]), .cur_time_high(cur[1]), .cur_date_low(cur[2]),
      .cur_date_high(cur[3]), .tamper_input_n(tamper_n), .half_tick_q(half), .sec_tick_q(sec),
      .alarm_irq_q(airq), .clock_irq_q(cirq), .clock_pin_q(pin), .clock_pin_oe_q(pin_oe),
      .sample_gate_q(gate), .stab_window_q(stab));
   rtcaux_ext_dev u_dev (.sys_clk(sys_clk), .pin(pin), .pin_oe(pin_oe), .gate(gate),
      .pulse_req(pulse_req), .tamper_n(tamper_n), .gate_len(glen), .unpowered(unpow));
   initial forever #5 sys_clk = ~sys_clk;
   // pulse counters, outputs stand one cycle
   always @(posedge sys_clk) begin
      if (airq === 1'b1) n_alm++;
      if (cirq === 1'b1) n_irq++;
      if (half === 1'b1) n_half++;
   end
   task summarize;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] x);
      check_count++;
      if (g !== x) begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = rdata;
   endtask
   // a wait that runs out is a mismatch, never a silent pass
   task tmo;
      num_errors++;
      $display("wrong value at %0t: wait timed out", $time);
      summarize();
   endtask
   task wsec;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (sec !== 1'b1 && n < 9000);
      if (n >= 9000) tmo();
   endtask
   // gate rises and falls again, so the measured length is final
   task wgate;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (gate !== 1'b1 && n < 400);
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (gate === 1'b1 && n < 500);
      if (n >= 400) tmo();
   endtask
   // divider programmed while stopped, so the count never overruns
   task per(input logic [15:0] dv, input logic [4:0] fv);
      wr(rtcaux_pkg::A_CTL1L, 16'h0000);
      wr(rtcaux_pkg::A_DIV, dv);
      wr(rtcaux_pkg::A_FINE_DIVIDE, {11'h000, fv});
      wr(rtcaux_pkg::A_CTL1L, 16'h8000);
      wsec();
      n_half = 0;
      wsec();
      chk(16'(n), 16'({dv, fv} + 21'h1));
      chk(16'(n_half), 16'h0002);
   endtask
   task newcur;
      for (i = 0; i < 4; i++) cur[i] <= 16'($random(seed));
      @(posedge sys_clk);
   endtask
   task cmpst;
      for (i = 0; i < 4; i++) begin
         rd(5'(rtcaux_pkg::A_STAMP0 + i), d);
         chk(d, e[i]);
      end
   endtask
   task tp;
      @(posedge sys_clk);
      pulse_req <= 1'b1;
      @(posedge sys_clk);
      pulse_req <= 1'b0;
      repeat (12) @(posedge sys_clk);
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      rd(rtcaux_pkg::A_DIV, d);
      chk(d, 16'h3fff);
      rd(5'h1f, d);
      chk(d, 16'h0000);
      f = 5'h04 + 5'($random(seed) & 7);
      per(16'h0000, f);
      per(16'h0000, f + 5'h01);
      per(16'h0001, f);
      per(16'h0000, 5'h07);
      wr(rtcaux_pkg::A_ALM0, 16'h0000);
      n_alm = 0;
      wr(rtcaux_pkg::A_CTL1H, 16'h8001);
      repeat (60) @(posedge sys_clk);
      chk(16'(n_alm), 16'h0002);
      rd(rtcaux_pkg::A_CTL1H, d);
      chk(d, 16'h0000);
      n_alm = 0;
      wr(rtcaux_pkg::A_CTL1H, 16'hc000);
      repeat (60) @(posedge sys_clk);
      rd(rtcaux_pkg::A_CTL1H, d);
      chk(d & 16'hc000, 16'hc000);
      chk(16'(n_alm > 10), 16'h0001);
      // written twice: a write in a fire cycle loses to hardware
      repeat (2) wr(rtcaux_pkg::A_CTL1H, 16'h0000);
      per(16'h0004, 5'h00);
      wr(rtcaux_pkg::A_CTL3L, 16'h0202);
      for (int ps = 0; ps < 2; ps++) begin
         wr(rtcaux_pkg::A_CTL2L, 16'(ps << 6));
         wr(rtcaux_pkg::A_CTL1L, 16'h86b0);
         wr(rtcaux_pkg::A_CTL1H, 16'hc100);
         wgate();
         chk(16'(glen), ps ? 16'h0020 : 16'h0002);
         repeat (2) wr(rtcaux_pkg::A_CTL1H, 16'h0000);
      end
      chk(16'(unpow), 16'h0000);
      wr(rtcaux_pkg::A_CTL1L, 16'h84b0);
      repeat (3) @(posedge sys_clk);
      chk(16'(pin), 16'h0001);
      wr(rtcaux_pkg::A_CTL3L, 16'h00ff);
      wr(rtcaux_pkg::A_CTL1L, 16'h8000);
      repeat (3) @(posedge sys_clk);
      chk(16'(stab), 16'h0001);
      newcur();
      e = cur;
      wr(rtcaux_pkg::A_CTL1L, 16'h8001);
      wr(rtcaux_pkg::A_STAT, 16'h0008);
      repeat (4) @(posedge sys_clk);
      rd(rtcaux_pkg::A_STAT, d);
      chk(d & 16'h0008, 16'h0008);
      cmpst();
      newcur();
      tp();
      cmpst();
      wr(rtcaux_pkg::A_STAT, 16'h0000);
      n_irq = 0;
      e = cur;
      tp();
      cmpst();
      chk(16'(n_irq), 16'h0001);
      wr(rtcaux_pkg::A_CTL1L, 16'h0000);
      wr(rtcaux_pkg::A_STAMP0, 16'h5a3c);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(rtcaux_pkg::A_STAMP0, d);
      chk(d, 16'h5a3c);
      por_n <= 1'b0;
      @(posedge sys_clk);
      por_n <= 1'b1;
      rd(rtcaux_pkg::A_STAMP0, d);
      chk(d, 16'h0000);
      summarize();
   end
endmodule
`default_nettype wire
